//--- status_update_request_exception_register.sv
/*
 Floating-point status word register: identification, control, trap
 enable and sticky flag bytes, masked read-modify-write over AXI4-Lite,
 exception resolution for the arithmetic datapath and one interrupt.
 Assumes the datapath and the bus master run on i_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module status_update_request_exception_register #(
   parameter logic [7:0] ID_BYTE = status_update_request_pkg::ID_BYTE_DEFAULT // Arbitrary id value
) (
   input  wire logic                                i_clk,
   input  wire logic                                i_reset,
   // AXI4-Lite write address
   input  wire logic                                i_awvalid,
   output logic                                     o_awready,
   input  wire logic [status_update_request_pkg::AXI_ADDR_W-1:0] i_awaddr,
   // AXI4-Lite write data
   input  wire logic                                i_wvalid,
   output logic                                     o_wready,
   input  wire logic [31:0]                         i_wdata,
   input  wire logic [3:0]                          i_wstrb,
   // AXI4-Lite write response
   output logic                                     o_bvalid,
   input  wire logic                                i_bready,
   output logic      [1:0]                          o_bresp,
   // AXI4-Lite read address
   input  wire logic                                i_arvalid,
   output logic                                     o_arready,
   input  wire logic [status_update_request_pkg::AXI_ADDR_W-1:0] i_araddr,
   // AXI4-Lite read data
   output logic                                     o_rvalid,
   input  wire logic                                i_rready,
   output logic      [31:0]                         o_rdata,
   output logic      [1:0]                          o_rresp,
   // Datapath side
   input  wire status_update_request_pkg::exc_event_t           i_exc,
   output status_update_request_pkg::exc_answer_t               o_answer,
   output logic                                     o_nan_control,
   output logic                                     o_irq
);

   // Write channel sequencing
   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,   // Gathering address and data
      WR_RESP    = 2'b10    // Response offered
   } wr_state_t;

   // Whole state of the block
   typedef struct packed {
      wr_state_t                         wr_state;
      logic                              awready;
      logic                              wready;
      logic                              bvalid;
      logic [1:0]                        bresp;
      logic                              arready;
      logic                              rvalid;
      logic [1:0]                        rresp;
      logic [31:0]                       rdata;
      logic                              have_aw;
      logic                              have_w;
      logic [status_update_request_pkg::AXI_ADDR_W-1:0] awaddr;
      logic [31:0]                       wdata;
      logic [3:0]                        wstrb;
      logic [status_update_request_pkg::EXC_N-1:0]   enables;
      logic [status_update_request_pkg::EXC_N-1:0]   flags;
      logic                              nan_ctrl;
      logic [31:0]                       upd_mask;
      logic [31:0]                       upd_flags;
      logic [31:0]                       upd_return;
      logic [status_update_request_pkg::IRQ_N-1:0]   irq_status;
      logic [status_update_request_pkg::IRQ_N-1:0]   irq_mask;
      logic                              irq;
      status_update_request_pkg::exc_answer_t        answer;
   } state_t;

   state_t                          st;          // Registered state
   state_t                          next_st;     // Next state
   logic                            upd;         // Update fires this cycle
   logic [31:0]                     upd_word;    // Flags word of the update
   logic [31:0]                     status_word; // Assembled status word
   logic [status_update_request_pkg::EXC_N-1:0] m_enables;   // Merged enables
   logic [status_update_request_pkg::EXC_N-1:0] m_flags;     // Merged flags
   logic [status_update_request_pkg::EXC_N-1:0] trap_bits;   // Exceptions trapping
   logic [status_update_request_pkg::EXC_N-1:0] flag_bits;   // Exceptions flagged

   // Word address match, low two bits ignored
   function automatic logic hit(input logic [status_update_request_pkg::AXI_ADDR_W-1:0] a,
                                input logic [7:0] ofs);
      hit = (a[status_update_request_pkg::AXI_ADDR_W-1:2] == ofs[status_update_request_pkg::AXI_ADDR_W-1:2]);
   endfunction : hit

   // Byte-lane merge of a write into a held word
   function automatic logic [31:0] lanes(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = data[8*b +: 8];
         end
      end
      lanes = r;
   endfunction : lanes

   // Status word; reserved bits read zero
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[status_update_request_pkg::ID_LSB +: 8] = ID_BYTE;
      status_word[status_update_request_pkg::ENABLE_LSB +: status_update_request_pkg::EXC_N] = st.enables;
      status_word[status_update_request_pkg::NAN_CTRL_BIT] = st.nan_ctrl;
      status_word[status_update_request_pkg::FLAG_LSB +: status_update_request_pkg::EXC_N] = st.flags;
   end

   // Update fires when a full write to the flags word is gathered
   assign upd = (st.wr_state == WR_COLLECT) && st.have_aw && st.have_w
                && hit(st.awaddr, status_update_request_pkg::OFS_UPD_FLAGS);
   assign upd_word = lanes(st.upd_flags, st.wdata, st.wstrb);

   // Field merge of update and exception report
   status_update_request_merge u_merge (
      .i_enables   (st.enables),
      .i_flags     (st.flags),
      .i_update    (upd),
      .i_mask      (st.upd_mask),
      .i_set       (upd_word),
      .i_exc       (i_exc),
      .o_enables   (m_enables),
      .o_flags     (m_flags),
      .o_trap_bits (trap_bits),
      .o_flag_bits (flag_bits)
   );

   // Next state
   always_comb begin
      logic                            rd_clear;
      logic [status_update_request_pkg::IRQ_N-1:0] irq_set;
      rd_clear = 1'b0;
      irq_set  = '0;
      next_st  = st;
      // Address and data taken in either order
      if (i_awvalid && st.awready) begin
         next_st.have_aw = 1'b1;
         next_st.awaddr  = i_awaddr;
      end
      if (i_wvalid && st.wready) begin
         next_st.have_w = 1'b1;
         next_st.wdata  = i_wdata;
         next_st.wstrb  = i_wstrb;
      end
      // Write execution and response
      case (st.wr_state)
         WR_COLLECT: begin
            if (st.have_aw && st.have_w) begin
               next_st.have_aw  = 1'b0;
               next_st.have_w   = 1'b0;
               next_st.bvalid   = 1'b1;
               next_st.bresp    = status_update_request_pkg::RESP_OKAY;
               next_st.wr_state = WR_RESP;
               if (hit(st.awaddr, status_update_request_pkg::OFS_UPD_MASK)) begin
                  next_st.upd_mask = lanes(st.upd_mask, st.wdata, st.wstrb);
               end else if (hit(st.awaddr, status_update_request_pkg::OFS_UPD_FLAGS)) begin
                  // Old word kept for the caller before any change
                  next_st.upd_flags  = upd_word;
                  next_st.upd_return = status_word;
                  irq_set[status_update_request_pkg::IRQ_UPDATE] = 1'b1;
               end else if (hit(st.awaddr, status_update_request_pkg::OFS_IRQ_MASK)) begin
                  if (st.wstrb[0]) begin
                     next_st.irq_mask = st.wdata[status_update_request_pkg::IRQ_N-1:0];
                  end
               end else if (hit(st.awaddr, status_update_request_pkg::OFS_CONTROL)) begin
                  if (st.wstrb[0]) begin
                     next_st.nan_ctrl = st.wdata[0];
                  end
               end else begin
                  // Read-only or unmapped word
                  next_st.bresp = status_update_request_pkg::RESP_SLVERR;
               end
            end
         end
         WR_RESP: begin
            if (i_bready) begin
               next_st.bvalid   = 1'b0;
               next_st.wr_state = WR_COLLECT;
            end
         end
         default: begin
            next_st.bvalid   = 1'b0;
            next_st.wr_state = WR_COLLECT;
         end
      endcase
      next_st.awready = !next_st.have_aw && (next_st.wr_state == WR_COLLECT);
      next_st.wready  = !next_st.have_w && (next_st.wr_state == WR_COLLECT);
      // Read channel
      if (i_arvalid && st.arready) begin
         next_st.arready = 1'b0;
         next_st.rvalid  = 1'b1;
         next_st.rresp   = status_update_request_pkg::RESP_OKAY;
         next_st.rdata   = 32'h0000_0000;
         if (hit(i_araddr, status_update_request_pkg::OFS_STATUS)) begin
            next_st.rdata = status_word;
         end else if (hit(i_araddr, status_update_request_pkg::OFS_UPD_MASK)) begin
            next_st.rdata = st.upd_mask;
         end else if (hit(i_araddr, status_update_request_pkg::OFS_UPD_FLAGS)) begin
            next_st.rdata = st.upd_flags;
         end else if (hit(i_araddr, status_update_request_pkg::OFS_UPD_RETURN)) begin
            next_st.rdata = st.upd_return;
         end else if (hit(i_araddr, status_update_request_pkg::OFS_IRQ_STATUS)) begin
            next_st.rdata[status_update_request_pkg::IRQ_N-1:0] = st.irq_status;
            rd_clear = 1'b1;
         end else if (hit(i_araddr, status_update_request_pkg::OFS_IRQ_MASK)) begin
            next_st.rdata[status_update_request_pkg::IRQ_N-1:0] = st.irq_mask;
         end else if (hit(i_araddr, status_update_request_pkg::OFS_CONTROL)) begin
            next_st.rdata[0] = st.nan_ctrl;
         end else begin
            next_st.rresp = status_update_request_pkg::RESP_SLVERR;
         end
      end else if (st.rvalid && i_rready) begin
         next_st.rvalid  = 1'b0;
         next_st.arready = 1'b1;
      end
      // Fields after update and exception
      next_st.enables = m_enables;
      next_st.flags   = m_flags;
      // Trap pulse, or default result released
      next_st.answer.trap       = |trap_bits;
      next_st.answer.cause      = trap_bits;
      next_st.answer.default_ok = i_exc.valid && (i_exc.bits != '0)
                                  && (trap_bits == '0);
      irq_set[status_update_request_pkg::IRQ_TRAP] = |trap_bits;
      irq_set[status_update_request_pkg::IRQ_FLAG] = |flag_bits;
      // Sticky events; a new event wins over the read clear
      next_st.irq_status = (rd_clear ? '0 : st.irq_status) | irq_set;
      next_st.irq        = |(next_st.irq_status & next_st.irq_mask);
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st          <= '0;
         st.wr_state <= WR_COLLECT;
         st.awready  <= 1'b1;
         st.wready   <= 1'b1;
         st.arready  <= 1'b1;
         st.enables  <= status_update_request_pkg::ENABLES_RESET;
         st.flags    <= status_update_request_pkg::FLAGS_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign o_awready     = st.awready;
   assign o_wready      = st.wready;
   assign o_bvalid      = st.bvalid;
   assign o_bresp       = st.bresp;
   assign o_arready     = st.arready;
   assign o_rvalid      = st.rvalid;
   assign o_rdata       = st.rdata;
   assign o_rresp       = st.rresp;
   assign o_answer      = st.answer;
   assign o_nan_control = st.nan_ctrl;
   assign o_irq         = st.irq;

   // Check helpers, formed apart from the merge module
   logic [status_update_request_pkg::EXC_N-1:0] exp_en;  // Enables an update should leave
   logic [status_update_request_pkg::EXC_N-1:0] exp_fl;  // Flags an update should leave
   logic [status_update_request_pkg::EXC_N-1:0] exc_on;  // Reported lanes that trap
   logic [status_update_request_pkg::EXC_N-1:0] exc_off; // Reported lanes that only flag
   logic [status_update_request_pkg::EXC_N-1:0] held_on; // Flags already set in trapping lanes
   assign exp_en  = (st.enables
                     & ~st.upd_mask[status_update_request_pkg::ENABLE_LSB +: status_update_request_pkg::EXC_N])
                    ^ upd_word[status_update_request_pkg::ENABLE_LSB +: status_update_request_pkg::EXC_N];
   assign exp_fl  = (st.flags
                     & ~st.upd_mask[status_update_request_pkg::FLAG_LSB +: status_update_request_pkg::EXC_N])
                    ^ upd_word[status_update_request_pkg::FLAG_LSB +: status_update_request_pkg::EXC_N];
   assign exc_on  = i_exc.bits & st.enables;
   assign exc_off = i_exc.bits & ~st.enables;
   assign held_on = st.flags & exc_on;

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   property p_update_apply;
      upd && !i_exc.valid |=> (st.enables == $past(exp_en)) && (st.flags == $past(exp_fl));
   endproperty
   a_update_apply: assert property (p_update_apply) else $error("update merge wrong");

   property p_toggle;
      upd && !i_exc.valid && !st.upd_mask[0] && upd_word[0] |=> st.flags[0] != $past(st.flags[0]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle pair did not toggle");

   property p_return_old;
      upd |=> st.upd_return == $past(status_word);
   endproperty
   a_return_old: assert property (p_return_old) else $error("return not old word");

   property p_reset_values;
      $past(i_reset) |-> st.enables == status_update_request_pkg::ENABLES_RESET
                         && st.flags == status_update_request_pkg::FLAGS_RESET;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset fields wrong");

   property p_id_fixed;
      status_word[31:24] == ID_BYTE && status_word[31];
   endproperty
   a_id_fixed: assert property (p_id_fixed) else $error("id byte altered");

   property p_reserved;
      status_word[23:21] == 3'h0 && status_word[7:5] == 3'h0
      && status_word[15:10] == 6'h00 && status_word[8] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_trap;
      i_exc.valid && (exc_on != '0)
      |=> o_answer.trap && !o_answer.default_ok && o_answer.cause == $past(exc_on);
   endproperty
   a_trap: assert property (p_trap) else $error("enabled exception did not trap");

   property p_trap_no_flag;
      i_exc.valid && (exc_on != '0) && !upd
      |=> (st.flags & $past(exc_on)) == $past(held_on);
   endproperty
   a_trap_no_flag: assert property (p_trap_no_flag) else $error("trapped lane set its flag");

   property p_flag;
      i_exc.valid && (exc_off != '0) && !upd
      |=> ((st.flags & $past(exc_off)) == $past(exc_off))
          && st.irq_status[status_update_request_pkg::IRQ_FLAG];
   endproperty
   a_flag: assert property (p_flag) else $error("disabled exception not flagged");

   property p_sticky;
      !upd && st.flags[2] |=> st.flags[2] [*2];
   endproperty
   a_sticky: assert property (p_sticky or (##1 upd)) else $error("flag lost");

   c_update: cover property (upd ##1 st.bvalid);
   c_trap: cover property (i_exc.valid ##1 o_answer.trap);
   c_flag_default: cover property (i_exc.valid ##1 o_answer.default_ok);
   c_irq: cover property (o_irq ##[1:20] !o_irq);

endmodule : status_update_request_exception_register

`default_nettype wire

//--- status_update_request_pkg.sv
/*
 Constants, field layout, register offsets and carrier types shared by the
 floating-point status word register and its update merge.
 Assumes one 40 MHz clock domain and a 32-bit AXI4-Lite register bus.
*/
// Function
// - New writable bits: old and not mask, xor flags (enables and flags only; NaN control set by control word)
// - Mask/flags pair: keep, toggle, clear, set
// - Update returns the word held before it
// - Reset: all trap enables set, flags clear
// - Fixed identification byte in bits 31 to 24
// - Id top bit hardware, next bit library/emulator
// - Trap enables in third byte, reserved top three
// - Enabled exception requests a trap, no flag
// - Disabled exception sets flag, default result passes
// - Flags in low byte, same order, reserved top
// - Second byte is control, bit 9 NaN control
package status_update_request_pkg;

   // Exception lanes, same order in enable and flag bytes
   localparam int          EXC_N           = 5;
   localparam int          EXC_INVALID     = 0;
   localparam int          EXC_DIVZERO     = 1;
   localparam int          EXC_OVERFLOW    = 2;
   localparam int          EXC_UNDERFLOW   = 3;
   localparam int          EXC_INEXACT     = 4;

   // Byte positions inside the status word
   localparam int          ID_LSB          = 24;
   localparam int          ENABLE_LSB      = 16;
   localparam int          CONTROL_LSB     = 8;
   localparam int          FLAG_LSB        = 0;
   localparam int          NAN_CTRL_BIT    = 9;

   // Identification byte; value is arbitrary, top bit marks hardware
   localparam logic [7:0]  ID_BYTE_DEFAULT = 8'ha5;

   // Reset values of the writable fields
   localparam logic [4:0]  ENABLES_RESET   = 5'h1f;
   localparam logic [4:0]  FLAGS_RESET     = 5'h00;

   // Register bus
   localparam int          AXI_ADDR_W      = 8;
   localparam logic [7:0]  OFS_STATUS      = 8'h00;
   localparam logic [7:0]  OFS_UPD_MASK    = 8'h04;
   localparam logic [7:0]  OFS_UPD_FLAGS   = 8'h08;
   localparam logic [7:0]  OFS_UPD_RETURN  = 8'h0c;
   localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h10;
   localparam logic [7:0]  OFS_IRQ_MASK    = 8'h14;
   localparam logic [7:0]  OFS_CONTROL     = 8'h18;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // Interrupt status bits
   localparam int          IRQ_N           = 3;
   localparam int          IRQ_TRAP        = 0;
   localparam int          IRQ_FLAG        = 1;
   localparam int          IRQ_UPDATE      = 2;

   // Exception report from the arithmetic datapath
   typedef struct packed {
      logic             valid;
      logic [EXC_N-1:0] bits;
   } exc_event_t;

   // Answer to the datapath and the processor
   typedef struct packed {
      logic             trap;
      logic             default_ok;
      logic [EXC_N-1:0] cause;
   } exc_answer_t;

endpackage : status_update_request_pkg

//--- status_update_request_merge.sv
/*
 Combinational merge of a masked update and an exception report into the
 trap enable and flag fields.
 Assumes its inputs come from registers of the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module status_update_request_merge (
   input  wire logic [status_update_request_pkg::EXC_N-1:0] i_enables,   // Current enables
   input  wire logic [status_update_request_pkg::EXC_N-1:0] i_flags,     // Current flags
   input  wire logic                            i_update,    // Update this cycle
   input  wire logic [31:0]                     i_mask,      // Update mask word
   input  wire logic [31:0]                     i_set,       // Update flags word
   input  wire status_update_request_pkg::exc_event_t       i_exc,       // Datapath report
   output logic      [status_update_request_pkg::EXC_N-1:0] o_enables,   // Next enables
   output logic      [status_update_request_pkg::EXC_N-1:0] o_flags,     // Next flags
   output logic      [status_update_request_pkg::EXC_N-1:0] o_trap_bits, // Exceptions trapping
   output logic      [status_update_request_pkg::EXC_N-1:0] o_flag_bits  // Exceptions flagged
);

   logic [status_update_request_pkg::EXC_N-1:0] upd_en;   // Enables after update
   logic [status_update_request_pkg::EXC_N-1:0] upd_fl;   // Flags after update
   logic [status_update_request_pkg::EXC_N-1:0] raised;   // Reported exceptions

   assign raised = i_exc.valid ? i_exc.bits : '0;

   // Per lane: keep, toggle, clear or set from mask and flags
   genvar g;
   generate
      for (g = 0; g < status_update_request_pkg::EXC_N; g++) begin : g_lane
         always_comb begin
            if (i_update) begin
               upd_en[g] = (i_enables[g] & ~i_mask[status_update_request_pkg::ENABLE_LSB + g])
                           ^ i_set[status_update_request_pkg::ENABLE_LSB + g];
               upd_fl[g] = (i_flags[g] & ~i_mask[status_update_request_pkg::FLAG_LSB + g])
                           ^ i_set[status_update_request_pkg::FLAG_LSB + g];
            end else begin
               upd_en[g] = i_enables[g];
               upd_fl[g] = i_flags[g];
            end
         end
      end
   endgenerate

   // Classification uses the enables held before any update
   assign o_trap_bits = raised & i_enables;
   assign o_flag_bits = raised & ~i_enables;
   assign o_enables   = upd_en;
   // Exception set wins over a clearing update in the same cycle
   assign o_flags     = upd_fl | o_flag_bits;

endmodule : status_update_request_merge

`default_nettype wire

//--- fp_dp_model.sv
/*
 Stand-in for the arithmetic datapath: issues one exception report per
 request and counts trap answers as runtime errors.
 Assumes the register block answers on the same clock, one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none

module fp_dp_model (
   input  wire logic                       i_clk,    // Block clock
   input  wire logic                       i_reset,  // Clears error count
   input  wire logic                       i_go,     // Issue one report
   input  wire logic [4:0]                 i_bits,   // Lanes to report
   input  wire status_update_request_pkg::exc_answer_t i_answer, // Answer from block
   output status_update_request_pkg::exc_event_t       o_exc,    // One-cycle report
   output status_update_request_pkg::exc_answer_t      o_last,   // Last answer seen
   output logic [7:0]                      o_errors  // Runtime errors seen
);
   // Report pulse; idle lanes flip so a stale value is never reused
   always_ff @(posedge i_clk) begin
      o_exc.valid <= i_go;
      o_exc.bits  <= i_go ? i_bits : ~o_exc.bits;
      if (i_answer.trap || i_answer.default_ok) begin
         o_last <= i_answer;
      end
      // Each trap becomes one runtime float error
      if (i_reset) begin
         o_errors <= 8'h00;
      end else if (i_answer.trap) begin
         o_errors <= o_errors + 8'h01;
      end
   end
endmodule : fp_dp_model
`default_nettype wire

//--- status_update_request_exception_register_tb_top.sv
/*
 Testbench for the status word register: update table, exceptions,
 interrupt, refused accesses and reset.
 Assumes fp_dp_model and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module status_update_request_exception_register_tb_top;
   logic clk, rst = 1'b1, awv = 1'b0, wv = 1'b0, bv, br = 1'b0, arv = 1'b0;
   logic awr, wrdy, arr, rv, rr = 1'b0, nan, irq, go = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00, errs;
   logic [31:0] wd = 32'h0000_0000, rdat;
   logic [1:0] bres, rres;
   logic [4:0] gbits = 5'h00;
   status_update_request_pkg::exc_event_t  exc;
   status_update_request_pkg::exc_answer_t ans, last;
   int mismatches = 0;
   int num_checks = 0;
   // Update table: mask, flags, expected low 24 bits afterwards
   typedef struct packed { logic [31:0] m, f; logic [23:0] e; } row_t;
   row_t rows [7] = '{
      '{32'h0000_0000, 32'h0000_0000, 24'h1f_0000},
      '{32'h0002_0000, 32'h0000_0000, 24'h1d_0000},
      '{32'h0000_0000, 32'h0000_0015, 24'h1d_0015},
      '{32'h0000_0011, 32'h0000_0001, 24'h1d_0005},
      '{32'hffff_ffff, 32'hffff_ffff, 24'h1f_001f},
      '{32'h0000_0000, 32'h001f_001f, 24'h00_0000},
      '{32'h001f_001f, 32'h0004_0000, 24'h04_0000}};

   status_update_request_exception_register i_dut (.i_clk(clk), .i_reset(rst),
      .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv),
      .o_wready(wrdy), .i_wdata(wd), .i_wstrb(4'hf), .o_bvalid(bv),
      .i_bready(br), .o_bresp(bres), .i_arvalid(arv), .o_arready(arr),
      .i_araddr(ara), .o_rvalid(rv), .i_rready(rr), .o_rdata(rdat),
      .o_rresp(rres), .i_exc(exc), .o_answer(ans), .o_nan_control(nan),
      .o_irq(irq));
   fp_dp_model i_dp (.i_clk(clk), .i_reset(rst), .i_go(go), .i_bits(gbits),
      .i_answer(ans), .o_exc(exc), .o_last(last), .o_errors(errs));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic tally_and_finish();
      if (mismatches == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Bus write; each channel released at its own handshake edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      int n;
      n = 0;
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= d;
      br <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
      end while (bv !== 1'b1 && n < 100);
      r = bres;
      br <= 1'b0;
      if (n >= 100) mismatches++;
      @(posedge clk);
   endtask : axi_wr

   // Bus read; data taken at the edge where rvalid is seen
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int n;
      n = 0;
      arv <= 1'b1;
      ara <= a;
      rr <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arv && arr) arv <= 1'b0;
      end while (rv !== 1'b1 && n < 100);
      d = rdat;
      r = rres;
      rr <= 1'b0;
      if (n >= 100) mismatches++;
      @(posedge clk);
   endtask : axi_rd

   // Compare the whole status word, id byte included
   task automatic rs(input logic [23:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(status_update_request_pkg::OFS_STATUS, d, r);
      chk(d, {status_update_request_pkg::ID_BYTE_DEFAULT, e});
   endtask : rs

   task automatic upd(input logic [31:0] m, input logic [31:0] f);
      logic [1:0] r;
      axi_wr(status_update_request_pkg::OFS_UPD_MASK, m, r);
      axi_wr(status_update_request_pkg::OFS_UPD_FLAGS, f, r);
   endtask : upd

   // One report from the datapath, then room for the answer
   task automatic exc_op(input logic [4:0] b);
      go <= 1'b1;
      gbits <= b;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : exc_op

   // Watchdog well beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      logic [31:0] d, prev;
      logic [1:0]  r;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rs(24'h1f_0000);
      prev = 32'ha51f_0000;
      foreach (rows[i]) begin
         upd(rows[i].m, rows[i].f);
         axi_rd(status_update_request_pkg::OFS_UPD_RETURN, d, r);
         chk(d, prev);
         rs(rows[i].e);
         prev = {status_update_request_pkg::ID_BYTE_DEFAULT, rows[i].e};
      end
      // Only overflow traps now; unmask the trap interrupt alone
      axi_wr(status_update_request_pkg::OFS_IRQ_MASK, 32'h0000_0001, r);
      exc_op(5'h06);
      chk(last, 7'h44);
      chk(irq, 1'b1);
      rs(24'h04_0002);
      axi_rd(status_update_request_pkg::OFS_IRQ_STATUS, d, r);
      chk(d, 32'h0000_0007);
      chk(irq, 1'b0);
      exc_op(5'h01);
      chk(last[6:5], 2'b01);
      chk(irq, 1'b0);
      exc_op(5'h10);
      rs(24'h04_0013);
      upd(32'h0000_0001, 32'h0000_0000);
      rs(24'h04_0012);
      // Refused accesses leave everything alone, then a control write sets NaN control
      axi_wr(status_update_request_pkg::OFS_STATUS, 32'hffff_ffff, r);
      chk(r, status_update_request_pkg::RESP_SLVERR);
      rs(24'h04_0012);
      axi_rd(8'h3c, d, r);
      chk(d, 32'h0000_0000);
      chk(r, status_update_request_pkg::RESP_SLVERR);
      axi_wr(status_update_request_pkg::OFS_CONTROL, 32'h0000_0001, r);
      chk(nan, 1'b1);
      rs(24'h04_0212);
      chk(errs, 8'h01);
      // Reset in mid-run restores the defaults
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rs(24'h1f_0000);
      chk({nan, irq}, 2'b00);
      tally_and_finish();
   end
endmodule : status_update_request_exception_register_tb_top
`default_nettype wire
